// file: counter_array_watchdog.sv
/*
  Programmable counter array core with channel 4 usable as the watchdog,
  four 16-bit PWM channels, and an AHB-Lite register slave.
  Assumes all inputs synchronous to hclk; wd_reset_req feeds the system reset
  logic, which in turn asserts hresetn.
*/
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps

// What this block does
// - 16-bit PWM: compare zero is always high, 0xFFFF shortest; disabled gives zero.
// - Watchdog enable makes channel 4 the watchdog: high byte compare, low byte offset.
// - Watchdog is enabled coming out of every reset.
// - Watchdog forces the counter running; run bit writes do not stop it.
// - Run bit reads back what software wrote, zero if never set.
// - Counter byte writes are ignored while the watchdog is enabled.
// - Clock select and idle suspend are frozen while the watchdog is enabled.
// - Channel 4 forced to software timer; its mode writes blocked under watchdog.
// - Channel 4 high byte write services: loads counter high plus offset.
// - Watchdog reset when counter low overflows with channel 4 high equal.
// - Timeout equals 256 times offset plus 256 minus counter low.
// - Writing one to channel 4 flag under watchdog forces a reset.
// - Setting enable or lock turns the watchdog on.
// - Lock holds the watchdog on until reset; else clearing enable disables.
// - Reset defaults: divide by 12, counter and offset zero, 3072 clocks.
// - Idle suspend pauses counting while the CPU idles; set before enabling.
// - Overflow flag set on 0xFFFF to 0x0000 wrap, interrupts when enabled, software clears.
// - Run bit 6 stops counter at 0, runs at 1, watchdog overrides.
// - Five compare flags set on match, interrupt when enabled, software clears.
// - Control bit 5 reads zero and ignores writes.
// - Clock select 000 is divide by 12, 001 divide by 4, 010 to 101 other sources, 110 and 111 none.
// - Under watchdog enable, other mode register bits are write protected.
// - Enable bit resets to one, lock bit to zero.
module counter_array_watchdog (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cpu_idle,
  input wire logic timer0_ovf,
  input wire logic ext_edge_in,
  input wire logic ext_clk_in,
  output logic [counter_array_pkg::NUM_CH-1:0] pwm_out,
  output logic counter_irq,
  output logic wd_reset_req
);
  import counter_array_pkg::*;

  function automatic logic pwm_level(input logic [15:0] cnt, input logic [15:0] val,
                                     input logic en);
    pwm_level = en && (cnt >= val);
  endfunction

  function automatic logic is_match(input logic [15:0] cnt, input logic [15:0] val,
                                    input logic en);
    is_match = en && (cnt == val);
  endfunction

  mode_s mode_q;
  mode_s mode_d;
  logic run_q;
  logic ovf_flag_q;
  logic [NUM_CH-1:0] flags_q;
  logic [NUM_CH-1:0] flags_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] ch_val_q [NUM_PWM_CH];
  logic [NUM_CH-1:0] ch_en_q;
  logic [NUM_CH-1:0] ch_en_d;
  logic [NUM_CH-1:0] ch_ie_q;
  logic [NUM_CH-1:0] ch_ie_d;
  logic [7:0] ch4_lo_q;
  logic [7:0] ch4_hi_q;
  logic [7:0] ch4_hi_d;
  logic [NUM_CH-1:0] pwm_q;
  logic [NUM_CH-1:0] pwm_d;
  logic wd_reset_q;
  logic [31:0] hrdata_q;
  bus_req_s req_q;
  logic rd_wait_q;
  logic [3:0] presc_q;
  logic edge_in_q;
  logic ext_clk_q;
  logic [2:0] ext_div_q;

  // Bus decode
  wire addr_take = hsel && hready && htrans[1];
  wire wr = req_q.valid && req_q.write && hready;
  wire [7:0] wbyte = hwdata[7:0];
  wire wr_ctrl = wr && (req_q.addr == OFF_CTRL);
  wire wr_mode = wr && (req_q.addr == OFF_MODE);
  wire wr_cnt_lo = wr && (req_q.addr == OFF_CNT_LO);
  wire wr_cnt_hi = wr && (req_q.addr == OFF_CNT_HI);
  wire wr_ch4_lo = wr && (req_q.addr == OFF_CH4_LO);
  wire wr_ch4_hi = wr && (req_q.addr == OFF_CH4_HI);
  wire wr_ch4_mode = wr && (req_q.addr == OFF_CH4_MODE);
  wire ch_hit = (req_q.addr >= OFF_CH_BASE) && (req_q.addr <= OFF_CH_LAST)
                && (req_q.addr[1:0] == 2'b00);
  wire [1:0] ch_idx = req_q.addr[3:2];
  wire wr_ch = wr && ch_hit;
  mode_s mode_w;
  assign mode_w = mode_s'(wbyte);

  // Watchdog state
  wire wd_on = mode_q.watchdog_enable || mode_q.watchdog_lock;
  wire counting = wd_on || run_q;

  // Timebase
  wire div12_tick = (presc_q == PRESC_LAST);
  wire div4_tick = (presc_q[1:0] == DIV4_PHASE);
  wire ext_edge_tick = edge_in_q && !ext_edge_in;
  wire ext_div_tick = ext_clk_in && !ext_clk_q && (ext_div_q == EXT_DIV_LAST);
  logic src_tick;
  always_comb
  begin
    case (mode_q.counter_clock_select)
      SEL_DIV12: src_tick = div12_tick;
      SEL_DIV4: src_tick = div4_tick;
      SEL_TIMER0: src_tick = timer0_ovf;
      SEL_EXT_EDGE: src_tick = ext_edge_tick;
      SEL_SYSTEM_CLOCK: src_tick = 1'b1;
      SEL_EXT_DIV8: src_tick = ext_div_tick;
      default: src_tick = 1'b0;
    endcase
  end

  wire suspended = mode_q.idle_suspend && cpu_idle;
  wire cnt_tick = counting && src_tick && !suspended;
  wire cnt_wrap = cnt_tick && (cnt_q == CNT_MAX);
  wire lo_wrap = cnt_tick && (cnt_q[7:0] == BYTE_MAX);
  wire [15:0] ch4_val = {ch4_hi_q, ch4_lo_q};
  wire ch4_active = ch_en_q[NUM_CH-1] || wd_on;

  // Timeout: high byte matched and low byte overflows; offset reaches it after
  // 256*offset + (256 - low) counter ticks from a service write.
  wire wd_timeout = wd_on && lo_wrap && (ch4_hi_q == cnt_q[15:8]);
  wire wd_force = wr_ctrl && wbyte[CTRL_CH4_FLAG_BIT] && wd_on;
  wire wd_fire = wd_timeout || wd_force;

  // Match events and PWM levels
  logic [NUM_CH-1:0] match;
  always_comb
  begin
    for (int i = 0; i < NUM_PWM_CH; i++)
    begin
      match[i] = cnt_tick && is_match(cnt_q, ch_val_q[i], ch_en_q[i]);
      pwm_d[i] = pwm_level(cnt_q, ch_val_q[i], ch_en_q[i]);
    end
    match[NUM_CH-1] = cnt_tick && is_match(cnt_q, ch4_val, ch4_active);
    // Software timer mode has no pin output, so the watchdog holds it low
    pwm_d[NUM_CH-1] = !wd_on && pwm_level(cnt_q, ch4_val, ch_en_q[NUM_CH-1]);
  end

  // Mode register next value
  always_comb
  begin
    mode_d = mode_q;
    if (wr_mode)
    begin
      mode_d.watchdog_enable = mode_w.watchdog_enable;
      if (!wd_on)
      begin
        mode_d = mode_w;
        mode_d.unused = 1'b0;
      end
      mode_d.watchdog_lock = mode_q.watchdog_lock || (!wd_on && mode_w.watchdog_lock);
    end
  end

  // Flags: hardware set wins over a software write of zero
  always_comb
  begin
    flags_d = flags_q;
    if (wr_ctrl)
      flags_d = wbyte[NUM_CH-1:0];
    flags_d = flags_d | match;
  end

  // Counter next value
  always_comb
  begin
    cnt_d = cnt_tick ? cnt_q + 16'h0001 : cnt_q;
    if (wr_cnt_lo && !wd_on)
      cnt_d[7:0] = wbyte;
    if (wr_cnt_hi && !wd_on)
      cnt_d[15:8] = wbyte;
  end

  // Channel 4 high byte and enables
  always_comb
  begin
    ch4_hi_d = ch4_hi_q;
    ch_en_d = ch_en_q;
    ch_ie_d = ch_ie_q;
    if (wr_ch4_hi)
    begin
      if (wd_on)
        ch4_hi_d = 8'(cnt_q[15:8] + ch4_lo_q);
      else
      begin
        ch4_hi_d = wbyte;
        ch_en_d[NUM_CH-1] = 1'b1;
      end
    end
    if (wr_ch4_lo && !wd_on)
      ch_en_d[NUM_CH-1] = 1'b0;
    if (wr_ch4_mode && !wd_on)
    begin
      ch_en_d[NUM_CH-1] = hwdata[CH4M_EN_BIT];
      ch_ie_d[NUM_CH-1] = hwdata[CH4M_IE_BIT];
    end
    if (wr_ch)
    begin
      ch_en_d[ch_idx] = hwdata[CHW_EN_BIT];
      ch_ie_d[ch_idx] = hwdata[CHW_IE_BIT];
    end
  end

  // Read mux
  logic [31:0] rd_word;
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (ch_hit)
      rd_word = {14'h0, ch_ie_q[ch_idx], ch_en_q[ch_idx], ch_val_q[ch_idx]};
    case (req_q.addr)
      OFF_CTRL: rd_word = {24'h000000, ovf_flag_q, run_q, 1'b0, flags_q};
      OFF_MODE: rd_word = {24'h000000, mode_q};
      OFF_CNT_LO: rd_word = {24'h000000, cnt_q[7:0]};
      OFF_CNT_HI: rd_word = {24'h000000, cnt_q[15:8]};
      OFF_CH4_LO: rd_word = {24'h000000, ch4_lo_q};
      OFF_CH4_HI: rd_word = {24'h000000, ch4_hi_q};
      OFF_CH4_MODE: rd_word = {30'h0, ch_ie_q[NUM_CH-1], ch_en_q[NUM_CH-1]};
      default: ;
    endcase
  end

  // Bus slave: writes complete with no wait, reads take one wait state so a
  // write just before is already visible.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      req_q <= '0;
      rd_wait_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      if (hready)
        req_q <= addr_take ? bus_req_s'{1'b1, hwrite, haddr[ADDR_W-1:0]} : '0;
      rd_wait_q <= hready && addr_take && !hwrite;
      if (rd_wait_q)
        hrdata_q <= rd_word;
    end
  end

  // Control, mode and flag registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_q <= mode_s'(MODE_RESET);
      run_q <= CTRL_RESET[CTRL_RUN_BIT];
      ovf_flag_q <= CTRL_RESET[CTRL_OVF_BIT];
      flags_q <= '0;
    end
    else
    begin
      mode_q <= mode_d;
      if (wr_ctrl)
        run_q <= wbyte[CTRL_RUN_BIT];
      ovf_flag_q <= cnt_wrap || (wr_ctrl ? wbyte[CTRL_OVF_BIT] : ovf_flag_q);
      flags_q <= flags_d;
    end
  end

  // Counter and channels
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_q <= CNT_RESET;
      ch4_lo_q <= OFFSET_RESET;
      ch4_hi_q <= OFFSET_RESET;
      ch_en_q <= '0;
      ch_ie_q <= '0;
      pwm_q <= '0;
      for (int i = 0; i < NUM_PWM_CH; i++)
        ch_val_q[i] <= CNT_RESET;
    end
    else
    begin
      cnt_q <= cnt_d;
      if (wr_ch4_lo)
        ch4_lo_q <= wbyte;
      ch4_hi_q <= ch4_hi_d;
      ch_en_q <= ch_en_d;
      ch_ie_q <= ch_ie_d;
      pwm_q <= pwm_d;
      if (wr_ch)
        ch_val_q[ch_idx] <= hwdata[15:0];
    end
  end

  // Timebase dividers; free running so the first tick comes at a fixed phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      presc_q <= '0;
      edge_in_q <= 1'b0;
      // High after reset: a pin resting high gives no false rising edge
      ext_clk_q <= 1'b1;
      ext_div_q <= '0;
    end
    else
    begin
      presc_q <= div12_tick ? 4'h0 : presc_q + 4'h1;
      edge_in_q <= ext_edge_in;
      ext_clk_q <= ext_clk_in;
      if (ext_clk_in && !ext_clk_q)
        ext_div_q <= ext_div_q + 3'h1;
    end
  end

  // Reset request pulse
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wd_reset_q <= 1'b0;
    else
      wd_reset_q <= wd_fire;
  end

  assign hreadyout = !rd_wait_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign pwm_out = pwm_q;
  assign wd_reset_req = wd_reset_q;
  assign counter_irq = (ovf_flag_q && mode_q.ovf_irq_en) || |(flags_q & ch_ie_q);

endmodule

// file: counter_array_pkg.sv
/*
  Shared constants, types and register map of the counter array watchdog block.
  Assumes a 32-bit AHB-Lite bus where each register takes one aligned word.
*/
package counter_array_pkg;

  localparam int ADDR_W = 8;
  localparam int NUM_CH = 5;
  localparam int NUM_PWM_CH = 4;

  // Register byte offsets within the block window
  localparam logic [ADDR_W-1:0] OFF_CH_BASE = 8'hc0;
  localparam logic [ADDR_W-1:0] OFF_CH_LAST = 8'hcc;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'hd8;
  localparam logic [ADDR_W-1:0] OFF_MODE = 8'hdc;
  localparam logic [ADDR_W-1:0] OFF_CNT_LO = 8'he0;
  localparam logic [ADDR_W-1:0] OFF_CNT_HI = 8'he4;
  localparam logic [ADDR_W-1:0] OFF_CH4_LO = 8'he8;
  localparam logic [ADDR_W-1:0] OFF_CH4_HI = 8'hec;
  localparam logic [ADDR_W-1:0] OFF_CH4_MODE = 8'hf0;

  // Control and flag register fields
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  localparam int CTRL_CH4_FLAG_BIT = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Channel word fields
  localparam int CHW_EN_BIT = 16;
  localparam int CHW_IE_BIT = 17;
  localparam int CH4M_EN_BIT = 0;
  localparam int CH4M_IE_BIT = 1;

  typedef enum logic [2:0] {
    SEL_DIV12 = 3'b000,
    SEL_DIV4 = 3'b001,
    SEL_TIMER0 = 3'b010,
    SEL_EXT_EDGE = 3'b011,
    SEL_SYSTEM_CLOCK = 3'b100,
    SEL_EXT_DIV8 = 3'b101
  } clk_sel_e;

  typedef struct packed {
    logic idle_suspend;
    logic watchdog_enable;
    logic watchdog_lock;
    logic unused;
    clk_sel_e counter_clock_select;
    logic ovf_irq_en;
  } mode_s;

  localparam logic [7:0] MODE_RESET = 8'h40;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
  } bus_req_s;

  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [7:0] OFFSET_RESET = 8'h00;

  // Timebase dividers
  localparam logic [3:0] PRESC_LAST = 4'hb;
  localparam logic [1:0] DIV4_PHASE = 2'b11;
  localparam logic [2:0] EXT_DIV_LAST = 3'h7;

endpackage

// file: wd_check_assertions.sv
/* Port checker for the counter array watchdog.
   Assumes one bus master and hready tied to the block's hreadyout. */
`timescale 1ns/1ps
module wd_check
  import counter_array_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic [NUM_CH-1:0] pwm_out,
  input wire logic wd_reset_req
);
  logic wr_q;
  logic on_q;
  logic lock_q;
  logic [7:0] a_q;
  wire req = hsel & hready & htrans[1];
  wire rd_req = req & !hwrite;
  wire wr_mode = wr_q & hready & (a_q == OFF_MODE);
  wire wr_ctrl = wr_q & hready & (a_q == OFF_CTRL);
  // Shadow of the watchdog state, built from bus writes only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      a_q <= 8'h00;
      on_q <= 1'b1;
      lock_q <= 1'b0;
    end
    else
    begin
      if (hready)
      begin
        wr_q <= req & hwrite;
        a_q <= haddr[7:0];
      end
      if (wr_mode & !lock_q)
        on_q <= hwdata[6] | (!on_q & hwdata[5]);
      if (wr_mode & !on_q)
        lock_q <= hwdata[5];
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_rd_req;
    rd_req;
  endsequence
  sequence s_rd_ans;
    !hreadyout ##1 hreadyout;
  endsequence
  AST_RD_WAIT: assert property (s_rd_req |=> s_rd_ans)
    else $error("read answer not after one wait state");
  AST_WR_READY: assert property (req & hwrite |=> hreadyout)
    else $error("write data phase stalled");
  AST_CTRL_B5: assert property (rd_req & (haddr[7:0] == OFF_CTRL) |->
    ##2 (hrdata[31:8] == 24'h0) && !hrdata[5])
    else $error("control unused bits not zero");
  AST_MODE_RD: assert property (rd_req & (haddr[7:0] == OFF_MODE) |=>
    ##1 (!hrdata[4] && ((hrdata[6] | hrdata[5]) == $past(on_q))))
    else $error("mode readback disagrees with watchdog state");
  AST_FORCE: assert property (wr_ctrl & on_q & hwdata[4] |-> ##[1:2] wd_reset_req)
    else $error("forced reset missing");
  AST_ONLY_ON: assert property ($rose(wd_reset_req) |-> $past(on_q))
    else $error("reset request while watchdog off");
  AST_PULSE: assert property (wd_reset_req |=> !wd_reset_req)
    else $error("reset request longer than one cycle");
  AST_PWM4: assert property (on_q & $past(on_q) & $past(on_q, 2) |-> !pwm_out[4])
    else $error("channel 4 output active under watchdog");
endmodule

bind counter_array_watchdog wd_check u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hrdata, .pwm_out, .wd_reset_req);

// file: tb.sv
/* Self-checking bench for the counter array watchdog.
   Assumes the checker is bound in and the bench is the only bus master. */
`timescale 1ns/1ps
module tb;
  import counter_array_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, counter_irq, wd_reset_req;
  logic [31:0] hrdata;
  logic [NUM_CH-1:0] pwm_out;
  logic [63:0] exp_q[$];
  logic [15:0] lfsr = 16'h001a;
  logic rd_dp = 1'b0;
  logic cpu_idle = 1'b0;
  logic [2:0] src_in = 3'b000;
  int n_errors = 0;
  int checked = 0;
  always #12.5 hclk = ~hclk;
  counter_array_watchdog dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .cpu_idle, .timer0_ovf(src_in[0]), .ext_edge_in(src_in[1]), .ext_clk_in(src_in[2]),
    .pwm_out, .counter_irq, .wd_reset_req);
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] e, input string m);
    checked++;
    if (got !== e)
    begin
      $display("[ERR] %0t %s", $time, m);
      n_errors++;
    end
  endtask
  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] e);
    cmp_val(got, e, "read data");
  endtask
  task automatic wait_rdy();
    for (int i = 0; i < 20; i++)
    begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        return;
    end
    cmp_val(32'h0, 32'h1, "bus hang");
    wrap_up();
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e});
    xfer(1'b0, a, 32'h0);
  endtask
  // Watchdog requests a system reset, so each test ends with one
  task automatic do_reset(input string t);
    $display("%0t test %s done", $time, t);
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  task automatic wd_wait(input logic want, input int lo, input int hi);
    int n;
    for (n = 0; n < hi && wd_reset_req !== 1'b1; n++)
      @(posedge hclk);
    cmp_val({31'h0, wd_reset_req}, {31'h0, want}, "reset request");
    if (want)
      cmp_val(32'(n >= lo), 32'h1, "reset request too early");
  endtask
  // Margin of 40 covers the counter low byte at service time and bus cycles
  task automatic wd_run(input logic [2:0] sel, input logic [7:0] off, input int cyc);
    wr(OFF_MODE, 32'h0);
    wr(OFF_MODE, {28'h0, sel, 1'b0});
    wr(OFF_CNT_LO, 32'h0);
    wr(OFF_CH4_LO, {24'h0, off});
    wr(OFF_MODE, {24'h0, 1'b0, 1'b1, 2'b00, sel, 1'b0});
    wr(OFF_CH4_HI, {16'h0, rnd()});
    rd(OFF_CH4_HI, {24'h0, off}, 32'hff);
    wd_wait(1'b1, cyc - 40, cyc + 40);
    do_reset("timeout");
  endtask
  // Sixteen pulses per run keep the external divide-by-8 phase aligned
  task automatic src_run(input logic [2:0] sel, input logic [7:0] e);
    wr(OFF_MODE, {28'h0, sel, 1'b0});
    wr(OFF_CNT_LO, 32'h0);
    wr(OFF_CTRL, 32'h40);
    repeat (16)
    begin
      src_in <= 3'b111;
      @(posedge hclk);
      src_in <= 3'b000;
      @(posedge hclk);
    end
    rd(OFF_CNT_LO, {24'h0, e}, 32'hff);
  endtask
  always @(posedge hclk)
  begin
    logic [63:0] e;
    if (hreadyout === 1'b1)
    begin
      if (rd_dp && exp_q.size() > 0)
      begin
        e = exp_q.pop_front();
        cmp_rd(hrdata & e[63:32], e[31:0]);
        cmp_val({31'h0, hresp}, 32'h0, "response");
      end
      rd_dp = hsel & htrans[1] & !hwrite;
    end
  end
  initial
  begin
    do_reset("start");
    wd_wait(1'b1, 3062, 3100);
    do_reset("default timeout");
    rd(OFF_CTRL, 32'h0, 32'hffffffff);
    rd(OFF_MODE, 32'h40, 32'hffffffff);
    wr(OFF_CNT_HI, 32'h5a);
    wr(OFF_MODE, 32'hee);
    rd(OFF_MODE, 32'h40, 32'hff);
    rd(OFF_CNT_HI, 32'h0, 32'hff);
    wr(OFF_CTRL, 32'h10);
    wd_wait(1'b1, 0, 4);
    do_reset("restrictions");
    wr(OFF_MODE, 32'h0);
    wr(OFF_CTRL, 32'h10);
    wd_wait(1'b0, 0, 30);
    rd(OFF_CTRL, 32'h10, 32'hff);
    wr(OFF_MODE, 32'h20);
    wr(OFF_MODE, 32'h0);
    rd(OFF_MODE, 32'h20, 32'h70);
    wr(OFF_CTRL, 32'h10);
    wd_wait(1'b1, 0, 4);
    do_reset("lock");
    wd_run(3'b100, 8'h02, 762);
    wd_run(3'b001, 8'h01, 2040);
    wr(OFF_MODE, 32'h08);
    wr(OFF_CH_BASE, 32'h30000);
    wr(OFF_CH_BASE + 8'h04, 32'h1ffff);
    wr(OFF_CH_BASE + 8'h08, 32'h0);
    cmp_val({31'h0, counter_irq}, 32'h0, "irq before run");
    wr(OFF_CTRL, 32'h40);
    repeat (50) @(posedge hclk);
    cmp_val({29'h0, pwm_out[2:0]}, 32'h1, "pwm levels");
    cmp_val({31'h0, counter_irq}, 32'h1, "compare irq");
    do_reset("pwm");
    cpu_idle <= 1'b1;
    wr(OFF_MODE, 32'h0);
    wr(OFF_MODE, 32'hc8);
    wd_wait(1'b0, 0, 300);
    cpu_idle <= 1'b0;
    wd_wait(1'b1, 250, 300);
    do_reset("idle");
    wr(OFF_MODE, 32'h0);
    src_run(3'b101, 8'h02);
    src_run(3'b010, 8'h10);
    src_run(3'b011, 8'h10);
    do_reset("sources");
    wrap_up();
  end
endmodule
